// ### design/cat_clock_alarm_thermostat.sv
// clock/calendar, alarm, thermostat and user memory core
`timescale 1ns/1ps
`include "cat_defines.svh"
module cat_clock_alarm_thermostat #(
  parameter int unsigned SECOND_CYCLES = `CAT_SECOND_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic linkClk,
  input wire logic linkSrst,
  input wire cat_pkg::cat_req_type req,
  output cat_pkg::cat_resp_type resp,
  input wire cat_pkg::cat_cfg_type cfg,
  input wire logic convDone,
  input wire logic [15:0] tempResult,
  output cat_pkg::cat_status_type status,
  output logic alarmPinOut,
  output logic alarmPinOe
);
  import cat_pkg::*;

  // ==========================================================
  // helpers
  // bcd step from lo to hi; bit 8 flags the wrap
  function automatic logic [8:0] bcdStep(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    logic [8:0] r;
    r = 9'h000;
    if (v >= hi) begin
      r = {1'b1, lo};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  function automatic logic [7:0] monthLength(input logic [7:0] month, input logic [7:0] year);
    logic [4:0] yearMod;
    logic [7:0] r;
    // ten is two modulo four, so tens*2 + units keeps the leap test exact
    yearMod = {year[6:4], 1'b0} + {1'b0, year[3:0]};
    r = 8'h31;
    unique case (month)
      8'h02: r = (yearMod[1:0] == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] resMask(input logic [1:0] res);
    logic [15:0] r;
    r = 16'hfff0;
    unique case (res)
      2'h0: r = 16'hff80;
      2'h1: r = 16'hffc0;
      2'h2: r = 16'hffe0;
      2'h3: r = 16'hfff0;
    endcase
    return r;
  endfunction

  // ==========================================================
  // link domain state
  typedef struct packed {
    cat_link_state_type fsm;
    logic reqTog;
    logic ackSync1;
    logic ackSync2;
    logic ackSeen;
    logic start;
    logic read;
    logic [7:0] cmd;
    logic [7:0] data;
    logic respValid;
    logic [7:0] respData;
  } cat_link_type;

  // ==========================================================
  // reference domain state
  typedef struct packed {
    cat_time_type tm;
    cat_alarm_type al;
    logic [15:0] highLimit;
    logic [15:0] lowLimit;
    logic [`CAT_SRAM_DEPTH-1:0][7:0] sram;
    logic [4:0] ptr;
    logic [31:0] tickCnt;
    logic thermalFlag;
    logic timeFlag;
    logic thermalLatch;
    logic timeLatch;
    logic matchPrev;
    logic reqSync1;
    logic reqSync2;
    logic reqSeen;
    logic ackTog;
    logic [7:0] rdData;
    logic pinOe;
  } cat_ref_type;

  cat_link_type lk;
  cat_link_type next_lk;
  cat_ref_type st;
  cat_ref_type next_st;

  // ==========================================================
  // link side: capture request, toggle across, wait for acknowledge
  always_comb begin
    next_lk = lk;
    next_lk.respValid = 1'b0;
    next_lk.ackSync1 = st.ackTog;
    next_lk.ackSync2 = lk.ackSync1;
    unique case (lk.fsm)
      LINK_IDLE: begin
        // requests arriving while busy are dropped; busy tells the framer
        if (req.valid) begin
          next_lk.start = req.start;
          next_lk.read = req.read;
          next_lk.cmd = req.cmd;
          next_lk.data = req.data;
          next_lk.reqTog = ~lk.reqTog;
          next_lk.fsm = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (lk.ackSync2 != lk.ackSeen) begin
          next_lk.ackSeen = lk.ackSync2;
          next_lk.respValid = 1'b1;
          next_lk.respData = st.rdData;
          next_lk.fsm = LINK_IDLE;
        end
      end
    endcase
    if (linkSrst) begin
      next_lk = '0;
      next_lk.fsm = LINK_IDLE;
      // keep the toggles aligned with the far side across a link reset
      next_lk.reqTog = lk.reqTog;
      next_lk.ackSeen = lk.ackSync2;
      next_lk.ackSync1 = st.ackTog;
      next_lk.ackSync2 = lk.ackSync1;
    end
  end

  always_ff @(posedge linkClk) begin
    lk <= next_lk;
  end

  assign resp.valid = lk.respValid;
  assign resp.busy = (lk.fsm == LINK_WAIT);
  assign resp.data = lk.respData;

  // ==========================================================
  // reference side: time base, alarms, register access
  always_comb begin
    logic tick;
    logic [8:0] s;
    logic [7:0] h;
    logic carry;
    logic match;
    logic [15:0] mask;
    logic [4:0] idx;
    logic active;
    logic drive;
    tick = 1'b0;
    s = 9'h000;
    h = 8'h00;
    carry = 1'b0;
    match = 1'b0;
    mask = resMask(cfg.resolution);
    idx = 5'h00;
    active = 1'b0;
    drive = 1'b0;
    next_st = st;
    next_st.reqSync1 = lk.reqTog;
    next_st.reqSync2 = st.reqSync1;

    // one-second time base, frozen while halted
    if (!st.tm.sec[`CAT_BIT_HALT]) begin
      if (st.tickCnt >= SECOND_CYCLES - 1) begin
        next_st.tickCnt = 32'h0;
        tick = 1'b1;
      end else begin
        next_st.tickCnt = st.tickCnt + 32'h1;
      end
    end

    if (tick) begin
      s = bcdStep({1'b0, st.tm.sec[6:0]}, 8'h00, 8'h59);
      next_st.tm.sec = {st.tm.sec[`CAT_BIT_HALT], s[6:0]};
      carry = s[8];
      if (carry) begin
        s = bcdStep(st.tm.min, 8'h00, 8'h59);
        next_st.tm.min = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        if (st.tm.hour[`CAT_BIT_12MODE]) begin
          h = {3'h0, st.tm.hour[4:0]};
          carry = 1'b0;
          if (h == 8'h12) begin
            next_st.tm.hour[4:0] = 5'h01;
          end else if (h == 8'h11) begin
            // 11 PM to 12 AM is midnight
            next_st.tm.hour[4:0] = 5'h12;
            next_st.tm.hour[`CAT_BIT_PM] = ~st.tm.hour[`CAT_BIT_PM];
            carry = st.tm.hour[`CAT_BIT_PM];
          end else begin
            s = bcdStep(h, 8'h01, 8'h12);
            next_st.tm.hour[4:0] = s[4:0];
          end
        end else begin
          s = bcdStep({2'h0, st.tm.hour[5:0]}, 8'h00, 8'h23);
          next_st.tm.hour[5:0] = s[5:0];
          carry = s[8];
        end
      end
      if (carry) begin
        s = bcdStep(st.tm.wday, 8'h01, 8'h07);
        next_st.tm.wday = s[7:0];
        s = bcdStep(st.tm.mday, 8'h01, monthLength(st.tm.month, st.tm.year));
        next_st.tm.mday = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        s = bcdStep(st.tm.month, 8'h01, 8'h12);
        next_st.tm.month = s[7:0];
        carry = s[8];
      end
      if (carry) begin
        s = bcdStep(st.tm.year, 8'h00, 8'h99);
        next_st.tm.year = s[7:0];
      end
    end

    // register access from the link
    if (st.reqSync2 != st.reqSeen) begin
      next_st.reqSeen = st.reqSync2;
      next_st.ackTog = ~st.ackTog;
      next_st.rdData = 8'h00;
      idx = lk.start ? 5'h00 : st.ptr;
      next_st.ptr = idx + 5'h01;
      unique case (lk.cmd)
        `CAT_CMD_TIME: begin
          next_st.timeFlag = 1'b0;
          unique case (idx)
            `CAT_OFS_SEC: begin
              next_st.rdData = st.tm.sec;
              if (!lk.read) begin
                next_st.tm.sec = lk.data & `CAT_MASK_SEC;
                // a new seconds value starts a whole second
                next_st.tickCnt = 32'h0;
              end
            end
            `CAT_OFS_MIN: begin
              next_st.rdData = st.tm.min;
              if (!lk.read) next_st.tm.min = lk.data & `CAT_MASK_MIN;
            end
            `CAT_OFS_HOUR: begin
              next_st.rdData = st.tm.hour;
              if (!lk.read) next_st.tm.hour = lk.data & `CAT_MASK_HOUR;
            end
            `CAT_OFS_WDAY: begin
              next_st.rdData = st.tm.wday;
              if (!lk.read) next_st.tm.wday = lk.data & `CAT_MASK_WDAY;
            end
            `CAT_OFS_MDAY: begin
              next_st.rdData = st.tm.mday;
              if (!lk.read) next_st.tm.mday = lk.data & `CAT_MASK_MDAY;
            end
            `CAT_OFS_MONTH: begin
              next_st.rdData = st.tm.month;
              if (!lk.read) next_st.tm.month = lk.data & `CAT_MASK_MONTH;
            end
            `CAT_OFS_YEAR: begin
              next_st.rdData = st.tm.year;
              if (!lk.read) next_st.tm.year = lk.data & `CAT_MASK_YEAR;
            end
            default: next_st.rdData = 8'h00;
          endcase
        end
        `CAT_CMD_ALARM: begin
          next_st.timeFlag = 1'b0;
          unique case (idx)
            `CAT_OFS_SEC: begin
              next_st.rdData = st.al.sec;
              if (!lk.read) next_st.al.sec = lk.data & `CAT_MASK_AL_SEC;
            end
            `CAT_OFS_MIN: begin
              next_st.rdData = st.al.min;
              if (!lk.read) next_st.al.min = lk.data & `CAT_MASK_AL_MIN;
            end
            `CAT_OFS_HOUR: begin
              next_st.rdData = st.al.hour;
              if (!lk.read) next_st.al.hour = lk.data & `CAT_MASK_AL_HOUR;
            end
            `CAT_OFS_WDAY: begin
              next_st.rdData = st.al.wday;
              if (!lk.read) next_st.al.wday = lk.data & `CAT_MASK_AL_WDAY;
            end
            default: next_st.rdData = 8'h00;
          endcase
        end
        `CAT_CMD_HIGH_LIMIT, `CAT_CMD_LOW_LIMIT: begin
          mask = resMask(cfg.resolution);
          if (lk.cmd == `CAT_CMD_HIGH_LIMIT) begin
            if (idx == `CAT_OFS_LIMIT_MSB) begin
              next_st.rdData = st.highLimit[15:8] & mask[15:8];
              if (!lk.read) next_st.highLimit[15:8] = lk.data & mask[15:8];
            end else if (idx == `CAT_OFS_LIMIT_LSB) begin
              next_st.rdData = st.highLimit[7:0] & mask[7:0];
              if (!lk.read) next_st.highLimit[7:0] = lk.data & mask[7:0];
            end
          end else begin
            if (idx == `CAT_OFS_LIMIT_MSB) begin
              next_st.rdData = st.lowLimit[15:8] & mask[15:8];
              if (!lk.read) next_st.lowLimit[15:8] = lk.data & mask[15:8];
            end else if (idx == `CAT_OFS_LIMIT_LSB) begin
              next_st.rdData = st.lowLimit[7:0] & mask[7:0];
              if (!lk.read) next_st.lowLimit[7:0] = lk.data & mask[7:0];
            end
          end
        end
        `CAT_CMD_SRAM: begin
          if (lk.start && !lk.read) begin
            // first written byte is the start address
            next_st.ptr = lk.data[4:0];
          end else begin
            next_st.rdData = st.sram[st.ptr];
            if (!lk.read) next_st.sram[st.ptr] = lk.data;
            next_st.ptr = st.ptr + 5'h01;
          end
        end
        default: begin
          next_st.ptr = st.ptr;
        end
      endcase
    end

    // clock alarm on the first cycle of a match; set beats a clear
    match = (st.tm.sec[6:0] == st.al.sec[6:0]) && (st.tm.min == st.al.min) &&
            (st.tm.hour[5:0] == st.al.hour[5:0]) && (st.tm.wday == st.al.wday);
    next_st.matchPrev = match;
    if (match && !st.matchPrev) begin
      next_st.timeFlag = 1'b1;
      next_st.timeLatch = 1'b1;
    end

    // thermostat with hysteresis
    mask = resMask(cfg.resolution);
    if (convDone) begin
      if ($signed(tempResult & mask) >= $signed(st.highLimit & mask)) begin
        next_st.thermalFlag = 1'b1;
        next_st.thermalLatch = 1'b1;
      end else if ($signed(tempResult & mask) < $signed(st.lowLimit & mask)) begin
        next_st.thermalFlag = 1'b0;
      end
    end

    // source select and open-drain drive
    active = (cfg.source[0] & next_st.thermalFlag) |
             (cfg.source[1] & next_st.timeFlag);
    drive = cfg.polarity ? ~active : active;
    next_st.pinOe = ~drive;

    if (srst) begin
      next_st = '0;
      next_st.tm = {`CAT_RST_SEC, `CAT_RST_MIN, `CAT_RST_HOUR, `CAT_RST_WDAY,
                    `CAT_RST_MDAY, `CAT_RST_MONTH, `CAT_RST_YEAR};
      next_st.al = {`CAT_RST_AL_SEC, `CAT_RST_AL_MIN, `CAT_RST_AL_HOUR, `CAT_RST_AL_WDAY};
      next_st.highLimit = `CAT_RST_HIGH_LIMIT;
      next_st.lowLimit = `CAT_RST_LOW_LIMIT;
      // user bytes have no defined reset value; they keep their contents through srst
      next_st.sram = st.sram;
      next_st.matchPrev = 1'b1;
      next_st.pinOe = 1'b1;
      next_st.reqSync1 = lk.reqTog;
      next_st.reqSync2 = st.reqSync1;
      next_st.reqSeen = st.reqSync2;
      next_st.ackTog = st.ackTog;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  assign status.thermalFlag = st.thermalFlag;
  assign status.timeFlag = st.timeFlag;
  assign status.thermalLatch = st.thermalLatch;
  assign status.timeLatch = st.timeLatch;
  assign alarmPinOut = 1'b0;
  assign alarmPinOe = st.pinOe;
endmodule

// ### common/cat_defines.svh
// constants of the clock, alarm and thermostat block
`ifndef CAT_DEFINES_SVH
`define CAT_DEFINES_SVH

`define CAT_CMD_TIME 8'hc0
`define CAT_CMD_ALARM 8'hc7
`define CAT_CMD_HIGH_LIMIT 8'ha1
`define CAT_CMD_LOW_LIMIT 8'ha2
`define CAT_CMD_SRAM 8'h17

`define CAT_OFS_SEC 5'h00
`define CAT_OFS_MIN 5'h01
`define CAT_OFS_HOUR 5'h02
`define CAT_OFS_WDAY 5'h03
`define CAT_OFS_MDAY 5'h04
`define CAT_OFS_MONTH 5'h05
`define CAT_OFS_YEAR 5'h06
`define CAT_OFS_LIMIT_MSB 5'h00
`define CAT_OFS_LIMIT_LSB 5'h01

`define CAT_BIT_HALT 7
`define CAT_BIT_12MODE 6
`define CAT_BIT_PM 5

`define CAT_MASK_SEC 8'hff
`define CAT_MASK_MIN 8'h7f
`define CAT_MASK_HOUR 8'h7f
`define CAT_MASK_WDAY 8'h07
`define CAT_MASK_MDAY 8'h3f
`define CAT_MASK_MONTH 8'h1f
`define CAT_MASK_YEAR 8'hff
`define CAT_MASK_AL_SEC 8'h7f
`define CAT_MASK_AL_MIN 8'h7f
`define CAT_MASK_AL_HOUR 8'h3f
`define CAT_MASK_AL_WDAY 8'h07

`define CAT_RST_SEC 8'h00
`define CAT_RST_MIN 8'h00
`define CAT_RST_HOUR 8'h52
`define CAT_RST_WDAY 8'h01
`define CAT_RST_MDAY 8'h01
`define CAT_RST_MONTH 8'h01
`define CAT_RST_YEAR 8'h00
`define CAT_RST_AL_SEC 8'h00
`define CAT_RST_AL_MIN 8'h00
`define CAT_RST_AL_HOUR 8'h12
`define CAT_RST_AL_WDAY 8'h01
`define CAT_RST_HIGH_LIMIT 16'h7d00
`define CAT_RST_LOW_LIMIT 16'h7c00

`define CAT_SECOND_NS 1000000000
`define CAT_REF_PERIOD_NS 25
`define CAT_SECOND_CYCLES (`CAT_SECOND_NS / `CAT_REF_PERIOD_NS)
`define CAT_SRAM_DEPTH 32

`endif

// ### common/cat_pkg.sv
// types of the clock, alarm and thermostat block
`include "cat_defines.svh"
package cat_pkg;
  typedef struct packed {
    logic valid;
    logic start;
    logic read;
    logic [7:0] cmd;
    logic [7:0] data;
  } cat_req_type;

  typedef struct packed {
    logic valid;
    logic busy;
    logic [7:0] data;
  } cat_resp_type;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] mday;
    logic [7:0] month;
    logic [7:0] year;
  } cat_time_type;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
  } cat_alarm_type;

  typedef struct packed {
    logic [1:0] source;
    logic polarity;
    logic [1:0] resolution;
  } cat_cfg_type;

  typedef struct packed {
    logic thermalFlag;
    logic timeFlag;
    logic thermalLatch;
    logic timeLatch;
  } cat_status_type;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_WAIT = 2'b10
  } cat_link_state_type;
endpackage

// ### dv/cat_checker_assertions.sv
// port checker of the clock, alarm and thermostat block
`timescale 1ns/1ps
module cat_checker (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic linkClk,
  input wire logic linkSrst,
  input wire cat_pkg::cat_req_type req,
  input wire cat_pkg::cat_resp_type resp,
  input wire cat_pkg::cat_cfg_type cfg,
  input wire logic convDone,
  input wire logic [15:0] tempResult,
  input wire cat_pkg::cat_status_type status,
  input wire logic alarmPinOut,
  input wire logic alarmPinOe
);
  import cat_pkg::*;
  // ====================
  // core side
  // pin follows the flags of the same edge and the source setting of the edge before
  pin_level_a: assert property (@(posedge ref_clk) disable iff (srst)
    alarmPinOe == ((($past(cfg.source[0]) & status.thermalFlag) |
    ($past(cfg.source[1]) & status.timeFlag)) == $past(cfg.polarity)))
    else $error("alarm pin level wrong");
  pin_drive_a: assert property (@(posedge ref_clk) disable iff (srst)
    alarmPinOut == 1'h0) else $error("alarm pin driven high");
  therm_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    !convDone |=> $stable(status.thermalFlag)) else $error("thermal flag moved unprompted");
  therm_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
    status.thermalFlag |-> ##[0:1] status.thermalLatch) else $error("thermal latch missing");
  time_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
    status.timeFlag |-> ##[0:1] status.timeLatch) else $error("time latch missing");
  // ====================
  // link side
  take_busy_a: assert property (@(posedge linkClk) disable iff (linkSrst)
    req.valid && !resp.busy |=> resp.busy) else $error("busy not raised");
  answer_time_a: assert property (@(posedge linkClk) disable iff (linkSrst)
    req.valid && !resp.busy |=> (!resp.valid)[*3] ##[1:16] resp.valid)
    else $error("answer early or missing");
  answer_pulse_a: assert property (@(posedge linkClk) disable iff (linkSrst)
    resp.valid |=> !resp.valid) else $error("answer longer than a cycle");
  data_stand_a: assert property (@(posedge linkClk) disable iff (linkSrst)
    $changed(resp.data) |-> resp.valid) else $error("read data changed between answers");
  cover property (@(posedge linkClk) req.valid && !resp.busy);
  cover property (@(posedge ref_clk) $rose(status.timeFlag));
  cover property (@(posedge ref_clk) $rose(status.thermalFlag));
  cover property (@(posedge ref_clk) $fell(status.thermalFlag));
endmodule

bind cat_clock_alarm_thermostat cat_checker u_chk (.ref_clk(ref_clk), .srst(srst),
  .linkClk(linkClk), .linkSrst(linkSrst), .req(req), .resp(resp), .cfg(cfg),
  .convDone(convDone), .tempResult(tempResult), .status(status),
  .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe));

// ### dv/cat_host_model.sv
// host model issuing link requests one at a time
`timescale 1ns/1ps
module cat_host_model (
  input wire logic linkClk,
  output cat_pkg::cat_req_type req,
  input wire cat_pkg::cat_resp_type resp
);
  import cat_pkg::*;
  // ====================
  // request task
  int gap = 0;
  int timeouts = 0;
  initial req = '0;
  task automatic xfer(input logic rd, input logic st, input logic [7:0] cmd,
      input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 'x;
    repeat (gap + 1) @(negedge linkClk);
    while (resp.busy !== 1'h0) @(negedge linkClk);
    req <= '{1'h1, st, rd, cmd, d};
    @(posedge linkClk);
    @(negedge linkClk);
    // released fields toggle so stale values never look valid
    req.valid <= 1'h0;
    req.cmd <= ~cmd;
    req.data <= ~d;
    while (n < 40 && resp.valid !== 1'h1) begin
      @(negedge linkClk);
      n++;
    end
    if (n < 40) q = resp.data;
    else timeouts++;
  endtask
endmodule

// ### dv/cat_clock_alarm_thermostat_tb_top.sv
// top testbench of the clock, alarm and thermostat block
`timescale 1ns/1ps
`include "cat_defines.svh"
module cat_clock_alarm_thermostat_tb_top;
  import cat_pkg::*;
  logic ref_clk;
  logic linkClk;
  logic srst;
  logic linkSrst;
  logic convDone;
  logic alarmPinOut;
  logic alarmPinOe;
  logic [15:0] tempResult;
  logic [7:0] q;
  cat_req_type req;
  cat_resp_type resp;
  cat_cfg_type cfg;
  cat_status_type status;
  int bad_count = 0;
  int n_tests = 0;
  logic [15:0] tt [7] = '{16'h1900, 16'h0a00, 16'h09f0, 16'h18f0, 16'h0000, 16'hf5e0, 16'hf5d0};
  logic te [7] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  // ====================
  // clocks, design and host
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    linkClk = 1'h0;
    #3;
    forever #6 linkClk = ~linkClk;
  end
  // short second keeps the calendar test brief
  cat_clock_alarm_thermostat #(.SECOND_CYCLES(200)) dut (.ref_clk(ref_clk), .srst(srst),
    .linkClk(linkClk), .linkSrst(linkSrst), .req(req), .resp(resp), .cfg(cfg),
    .convDone(convDone), .tempResult(tempResult), .status(status),
    .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe));
  cat_host_model host (.linkClk(linkClk), .req(req), .resp(resp));
  // ====================
  // tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rds(input logic [7:0] c, input int n, input logic [55:0] e, input logic st);
    for (int i = 0; i < n; i++) begin
      host.xfer(1'h1, st && i == 0, c, 8'h00, q);
      chk(16'(q), 16'(e[8*(n-1-i) +: 8]));
    end
  endtask
  task automatic wrs(input logic [7:0] c, input int n, input logic [55:0] d, input logic st);
    for (int i = 0; i < n; i++) host.xfer(1'h0, st && i == 0, c, d[8*(n-1-i) +: 8], q);
  endtask
  task automatic conv(input logic [15:0] t, input logic e);
    @(negedge ref_clk);
    tempResult = t;
    convDone = 1'h1;
    @(negedge ref_clk);
    convDone = 1'h0;
    chk(16'(status.thermalFlag), 16'(e));
    chk(16'(alarmPinOe), 16'(!e));
  endtask
  task automatic end_sim();
    // a missing answer on the link counts against the run
    bad_count += host.timeouts;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ====================
  // tests
  initial begin
    srst = 1'h1;
    linkSrst = 1'h1;
    convDone = 1'h0;
    tempResult = 16'h0000;
    cfg = '{2'h0, 1'h0, 2'h3};
    repeat (20) @(negedge ref_clk);
    srst = 1'h0;
    linkSrst = 1'h0;
    repeat (8) @(negedge ref_clk);
    chk(16'(alarmPinOe), 16'h1);
    chk(16'(status), 16'h0);
    rds(`CAT_CMD_TIME, 7, 56'h00005201010100, 1'h1);
    rds(`CAT_CMD_ALARM, 4, 56'h00001201, 1'h1);
    rds(`CAT_CMD_HIGH_LIMIT, 2, 56'h7d00, 1'h1);
    rds(`CAT_CMD_LOW_LIMIT, 2, 56'h7c00, 1'h1);
    rds(8'h55, 1, 56'h00, 1'h1);
    $display("reset values done");
    wrs(`CAT_CMD_ALARM, 4, 56'hffffffff, 1'h1);
    rds(`CAT_CMD_ALARM, 4, 56'h7f7f3f07, 1'h1);
    $display("alarm fixed bits done");
    @(negedge ref_clk);
    cfg.resolution = 2'h0;
    wrs(`CAT_CMD_HIGH_LIMIT, 2, 56'h19ff, 1'h1);
    rds(`CAT_CMD_HIGH_LIMIT, 2, 56'h1980, 1'h1);
    @(negedge ref_clk);
    cfg = '{2'h1, 1'h0, 2'h3};
    // no conversions run while limits change
    foreach (tt[i]) begin
      if (i == 0) wrs(`CAT_CMD_HIGH_LIMIT, 2, 56'h1900, 1'h1);
      if (i == 0) wrs(`CAT_CMD_LOW_LIMIT, 2, 56'h0a00, 1'h1);
      if (i == 4) wrs(`CAT_CMD_HIGH_LIMIT, 2, 56'hff80, 1'h1);
      if (i == 4) wrs(`CAT_CMD_LOW_LIMIT, 2, 56'hf5e0, 1'h1);
      conv(tt[i], te[i]);
    end
    chk(16'(status.thermalLatch), 16'h1);
    $display("thermostat done");
    @(negedge ref_clk);
    cfg = '{2'h2, 1'h1, 2'h3};
    wrs(`CAT_CMD_ALARM, 4, 56'h00001201, 1'h1);
    wrs(`CAT_CMD_TIME, 7, 56'h58597107280223, 1'h1);
    for (int i = 0; i < 800 && status.timeFlag !== 1'h1; i++) @(negedge ref_clk);
    chk(16'(status.timeFlag), 16'h1);
    chk(16'(alarmPinOe), 16'h1);
    rds(`CAT_CMD_TIME, 7, 56'h00005201010323, 1'h1);
    repeat (4) @(negedge ref_clk);
    chk(16'(status.timeFlag), 16'h0);
    chk(16'(alarmPinOe), 16'h0);
    chk(16'(status.timeLatch), 16'h1);
    $display("calendar and clock alarm done");
    // 24-hour mode, leap year day 28 rolls to 29
    wrs(`CAT_CMD_TIME, 7, 56'h59592303280224, 1'h1);
    repeat (220) @(negedge ref_clk);
    rds(`CAT_CMD_TIME, 7, 56'h00000004290224, 1'h1);
    wrs(`CAT_CMD_TIME, 1, 56'h80, 1'h1);
    repeat (300) @(negedge ref_clk);
    rds(`CAT_CMD_TIME, 1, 56'h80, 1'h1);
    $display("leap day and halt done");
    host.gap = 3;
    wrs(8'h17, 1, 56'h1e, 1'h1);
    wrs(8'h17, 3, 56'ha0a1a2, 1'h0);
    wrs(8'h17, 1, 56'h1e, 1'h1);
    rds(8'h17, 3, 56'ha0a1a2, 1'h0);
    $display("user memory done");
    end_sim();
  end
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
endmodule
